// ### design/print_defines.svh
// Timing, geometry and motor constants for the thermal line print sequencer.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef PRINT_DEFINES_SVH
`define PRINT_DEFINES_SVH

// ----------------------------------------------------------------------
// Head geometry
// ----------------------------------------------------------------------
`define LINE_DOTS 432
`define GROUPS 3
`define GROUP_DOTS 144
`define LIMIT_LOW 10'h090
`define LIMIT_HIGH 10'h120
`define FIX_LOW_PASSES 2'h3
`define FIX_HIGH_PASSES 2'h2

// ----------------------------------------------------------------------
// Timing (ns figures and derived cycle counts)
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define XFER_HALF_NS 20
`define XFER_HALF_CYC ((`XFER_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LATCH_NS 100
`define LATCH_CYC ((`LATCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Motor excitation, order {B_n, A_n, B, A}
// ----------------------------------------------------------------------
`define PHASE_INIT 4'h9
`define MOTOR_OFF 4'h0

`endif

// ### design/print_pkg.sv
// Types shared by the thermal line print sequencer.
// Assumes print_defines.svh is compiled alongside.
package print_pkg;

   typedef enum logic [2:0] {
      S_IDLE,
      S_WAKE,
      S_LATCH,
      S_HEAT,
      S_HOLD
   } seq_state_t;

   // Pass count and the strobe groups fired in each pass
   typedef struct packed {
      logic [1:0] npass;
      logic [2:0][2:0] mask;
   } pass_plan_t;

endpackage

// ### design/print_sequencer.sv
// Host-side controller for a line thermal print head and its feed stepper.
// Assumes configuration inputs come from logic on clk and stay stable
// while busy; line data is offered with a valid/ready handshake.
//
// Functional notes
// [RL1] Maximum simultaneously heated dots is configured as 144 or 288.
// [RL2] Variable mode splits each line so no pass exceeds the dot limit.
// [RL3] Idle: motor windings unexcited, no strobes asserted.
// [RL4] Job start re-applies the last motor phase and shifts the first line.
// [RL5] Each line: advance motor one step, then latch the shifted line.
// [RL6] Head moves its shift path into the output register on latch.
// [RL7] Head heats latched dots only while their strobe group is asserted.
// [RL8] Next line is shifted in while the current line heats.
// [RL9] Limit 144, up to 144 dots: one pass, all groups together.
// [RL10] Limit 144, 145 to 288 dots: two passes (whole groups are packed, so a spread such as 100/100/80 takes three).
// [RL11] Limit 144, 289 to 432 dots: three passes.
// [RL12] Next motor step waits until all passes of the line finish.
// [RL13] Pass length comes from the temperature corrected pulse width.
// [RL14] Limit 288 in variable mode: one or two passes by dot count.
// [RL15] Fixed mode: same pass count for every line, three groups.
// [RL16] Fixed mode with limit 288: two passes per line.
// [RL17] Head link: serial data, transfer clock, latch, three strobes.
// [RL18] Single energy after an unprinted line, continuous after a printed one.
// [RL19] Motor steps through a fixed four phase cycle, one step per line.
`timescale 1ns/1ps
`default_nettype none
`include "print_defines.svh"

module print_sequencer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Configuration
   input wire logic limit_high,
   input wire logic fixed_division,
   input wire logic [19:0] pulse_single,
   input wire logic [19:0] pulse_cont,
   input wire logic [23:0] step_cycles,
   // Dot line stream
   input wire logic line_valid,
   output logic line_ready,
   input wire logic [`LINE_DOTS-1:0] line_data,
   output logic busy,
   // Head pins
   output logic serial_print_bit,
   output logic xfer_clk,
   output logic row_capture,
   output logic [2:0] heat_pulse_group,
   // Motor pins
   output logic [3:0] motor_phase
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] count_dots(input logic [`GROUP_DOTS-1:0] v);
      logic [7:0] n;
      n = 8'h00;
      for (int i = 0; i < `GROUP_DOTS; i++) begin
         n = n + {7'h00, v[i]};
      end
      return n;
   endfunction

   // Groups are packed in order; a pass is closed once the next group would
   // overflow the limit. Whole groups are the unit, so an awkward spread of
   // dots can cost one extra pass; the limit is never exceeded.
   function automatic print_pkg::pass_plan_t plan_passes(
      input logic [2:0][7:0] cnt,
      input logic high,
      input logic fixed
   );
      print_pkg::pass_plan_t p;
      logic [9:0] acc;
      logic [9:0] lim;
      logic [1:0] k;
      p = '0;
      acc = 10'h000;
      k = 2'h0;
      lim = high ? `LIMIT_HIGH : `LIMIT_LOW; // RL1
      if (fixed) begin
         for (int g = 0; g < `GROUPS; g++) begin
            if (high) begin
               p.mask[g >> 1][g] = 1'b1; // RL16
            end else begin
               p.mask[g][g] = 1'b1; // RL15
            end
         end
         p.npass = high ? `FIX_HIGH_PASSES : `FIX_LOW_PASSES;
      end else begin
         for (int g = 0; g < `GROUPS; g++) begin
            if (p.mask[k] != 3'h0 && acc + {2'b00, cnt[g]} > lim) begin
               k = k + 2'h1; // RL2 RL10 RL11 RL14
               acc = 10'h000;
            end
            p.mask[k][g] = 1'b1; // RL9
            acc = acc + {2'b00, cnt[g]};
         end
         p.npass = k + 2'h1;
      end
      return p;
   endfunction

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   print_pkg::seq_state_t state_reg;
   print_pkg::pass_plan_t plan_reg;
   logic [`LINE_DOTS-1:0] sreg_reg;
   logic [8:0] bits_left_reg;
   logic [3:0] div_reg;
   logic shift_busy_reg;
   logic line_held_reg;
   logic xfer_clk_reg;
   logic data_bit_reg;
   logic [7:0] grp_cnt_reg [`GROUPS];
   logic [9:0] total_dots;
   logic take;
   logic step_go;
   logic capture_go;
   logic [4:0] lat_cnt_reg;
   logic [19:0] heat_cnt_reg;
   logic [19:0] heat_width_reg;
   logic [1:0] pass_reg;
   logic [23:0] step_cnt_reg;
   logic printed_reg;
   logic motor_on_reg;
   logic [3:0] held_phase_reg;
   logic row_capture_reg;
   logic [2:0] strobe_reg;

   // ----------------------------------------------------------------------
   // Handshake and shared strobes
   // ----------------------------------------------------------------------
   // A line is only taken after the previous one has left the shift path,
   // so the latch never sees a half shifted row.
   assign line_ready = !rst && !shift_busy_reg && !line_held_reg;
   assign take = line_valid && line_ready;
   assign busy = state_reg != print_pkg::S_IDLE;
   assign step_go = (state_reg == print_pkg::S_WAKE || state_reg == print_pkg::S_HOLD)
                    && line_held_reg && step_cnt_reg == 24'h00_0000;
   assign capture_go = state_reg == print_pkg::S_LATCH
                       && lat_cnt_reg == 5'(`LATCH_CYC - 1);
   assign total_dots = {2'b00, grp_cnt_reg[0]} + {2'b00, grp_cnt_reg[1]}
                       + {2'b00, grp_cnt_reg[2]};

   // ----------------------------------------------------------------------
   // Serial transfer to the head
   // ----------------------------------------------------------------------
   // Data changes on the falling transfer edge, the head samples on rising.
   always_ff @(posedge clk) begin
      if (rst) begin
         sreg_reg <= '0;
         bits_left_reg <= 9'h000;
         div_reg <= 4'h0;
         shift_busy_reg <= 1'b0;
         line_held_reg <= 1'b0;
         xfer_clk_reg <= 1'b0;
         data_bit_reg <= 1'b0;
      end else if (take) begin
         sreg_reg <= line_data; // RL4 RL8
         bits_left_reg <= 9'(`LINE_DOTS);
         div_reg <= 4'h0;
         shift_busy_reg <= 1'b1;
         xfer_clk_reg <= 1'b0;
         data_bit_reg <= line_data[`LINE_DOTS-1];
      end else if (shift_busy_reg) begin
         if (div_reg == 4'(`XFER_HALF_CYC - 1)) begin
            div_reg <= 4'h0;
            if (!xfer_clk_reg) begin
               xfer_clk_reg <= 1'b1; // RL17
            end else begin
               xfer_clk_reg <= 1'b0;
               sreg_reg <= {sreg_reg[`LINE_DOTS-2:0], 1'b0};
               data_bit_reg <= sreg_reg[`LINE_DOTS-2];
               bits_left_reg <= bits_left_reg - 9'h001;
               if (bits_left_reg == 9'h001) begin
                  shift_busy_reg <= 1'b0;
                  line_held_reg <= 1'b1;
                  data_bit_reg <= 1'b0;
               end
            end
         end else begin
            div_reg <= div_reg + 4'h1;
         end
      end else if (capture_go) begin
         line_held_reg <= 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `GROUPS; g++) begin : grp_count
         always_ff @(posedge clk) begin
            if (rst) begin
               grp_cnt_reg[g] <= 8'h00;
            end else if (take) begin
               grp_cnt_reg[g] <= count_dots(line_data[g*`GROUP_DOTS +: `GROUP_DOTS]);
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= print_pkg::S_IDLE;
      end else begin
         unique case (state_reg)
            print_pkg::S_IDLE: begin
               if (shift_busy_reg || line_held_reg) begin
                  state_reg <= print_pkg::S_WAKE; // RL4
               end
            end
            print_pkg::S_WAKE: begin
               if (step_go) begin
                  state_reg <= print_pkg::S_LATCH;
               end
            end
            print_pkg::S_LATCH: begin
               if (capture_go) begin
                  state_reg <= print_pkg::S_HEAT;
               end
            end
            print_pkg::S_HEAT: begin
               if (heat_cnt_reg <= 20'h0_0001 && pass_reg + 2'h1 >= plan_reg.npass) begin
                  state_reg <= print_pkg::S_HOLD;
               end
            end
            print_pkg::S_HOLD: begin
               if (step_go) begin
                  state_reg <= print_pkg::S_LATCH; // RL12
               end else if (step_cnt_reg == 24'h00_0000 && !shift_busy_reg
                            && !line_held_reg) begin
                  state_reg <= print_pkg::S_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Line latch
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         lat_cnt_reg <= 5'h00;
         row_capture_reg <= 1'b0;
      end else if (step_go) begin
         lat_cnt_reg <= 5'h00;
         row_capture_reg <= 1'b1; // RL5 RL6
      end else if (capture_go) begin
         row_capture_reg <= 1'b0;
      end else if (state_reg == print_pkg::S_LATCH) begin
         lat_cnt_reg <= lat_cnt_reg + 5'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Heating passes
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         plan_reg <= '0;
         heat_width_reg <= 20'h0_0000;
         printed_reg <= 1'b0;
      end else if (step_go) begin
         plan_reg <= plan_passes({grp_cnt_reg[2], grp_cnt_reg[1], grp_cnt_reg[0]},
                                 limit_high, fixed_division);
         heat_width_reg <= printed_reg ? pulse_cont : pulse_single; // RL18 RL13
         printed_reg <= total_dots != 10'h000;
      end else if (state_reg == print_pkg::S_IDLE) begin
         printed_reg <= 1'b0; // RL18
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         strobe_reg <= 3'h0;
         heat_cnt_reg <= 20'h0_0000;
         pass_reg <= 2'h0;
      end else if (capture_go) begin
         strobe_reg <= plan_reg.mask[0]; // RL7
         heat_cnt_reg <= heat_width_reg; // RL13
         pass_reg <= 2'h0;
      end else if (state_reg == print_pkg::S_HEAT) begin
         if (heat_cnt_reg > 20'h0_0001) begin
            heat_cnt_reg <= heat_cnt_reg - 20'h0_0001;
         end else if (pass_reg + 2'h1 < plan_reg.npass) begin
            pass_reg <= pass_reg + 2'h1;
            strobe_reg <= plan_reg.mask[pass_reg + 2'h1]; // RL10 RL11
            heat_cnt_reg <= heat_width_reg;
         end else begin
            strobe_reg <= 3'h0;
         end
      end else begin
         strobe_reg <= 3'h0; // RL3
      end
   end

   // ----------------------------------------------------------------------
   // Feed motor
   // ----------------------------------------------------------------------
   // The step timer keeps the motor at its rate even when heating is short;
   // a long heat simply leaves it expired, so the step waits for heat.
   always_ff @(posedge clk) begin
      if (rst) begin
         step_cnt_reg <= 24'h00_0000;
      end else if (step_go || (state_reg == print_pkg::S_IDLE
                               && (shift_busy_reg || line_held_reg))) begin
         step_cnt_reg <= step_cycles;
      end else if (step_cnt_reg != 24'h00_0000) begin
         step_cnt_reg <= step_cnt_reg - 24'h00_0001;
      end
   end

   // Phase is kept across standstill so restart resumes the same position.
   always_ff @(posedge clk) begin
      if (rst) begin
         motor_on_reg <= 1'b0;
         held_phase_reg <= `PHASE_INIT;
      end else begin
         if (step_go) begin
            held_phase_reg <= {held_phase_reg[2:0], held_phase_reg[3]}; // RL19 RL5
         end
         if (state_reg == print_pkg::S_IDLE) begin
            motor_on_reg <= shift_busy_reg || line_held_reg; // RL4
         end else if (state_reg == print_pkg::S_HOLD && step_cnt_reg == 24'h00_0000
                      && !step_go && !shift_busy_reg && !line_held_reg) begin
            motor_on_reg <= 1'b0; // RL3
         end
      end
   end

   // ----------------------------------------------------------------------
   // Pin outputs
   // ----------------------------------------------------------------------
   assign serial_print_bit = data_bit_reg;
   assign xfer_clk = xfer_clk_reg;
   assign row_capture = row_capture_reg;
   assign heat_pulse_group = strobe_reg;
   assign motor_phase = motor_on_reg ? held_phase_reg : `MOTOR_OFF; // RL3

endmodule // print_sequencer

`default_nettype wire

// ### sim/seq_props_properties.sv
// Pin-level properties of the thermal line print sequencer.
// Bound to print_sequencer; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "print_defines.svh"
module seq_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Watched outputs
   input wire logic busy,
   input wire logic serial_print_bit,
   input wire logic xfer_clk,
   input wire logic row_capture,
   input wire logic [2:0] heat_pulse_group,
   input wire logic [3:0] motor_phase
);
   localparam int CAP = `LATCH_CYC;
   logic [3:0] ph_reg;
   logic [3:0] held_reg;
   logic [7:0] cap_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      ph_reg <= motor_phase;
   end
   // Phase memory outlives idle, as the rotor position does
   always_ff @(posedge clk) begin
      if (rst) begin
         held_reg <= `PHASE_INIT;
      end else if (motor_phase != 4'h0) begin
         held_reg <= motor_phase;
      end
   end
   always_ff @(posedge clk) begin
      cap_reg <= row_capture ? cap_reg + 8'h01 : 8'h00;
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_idle;
      !busy |-> motor_phase == 4'h0 && heat_pulse_group == 3'h0 && !row_capture;
   endproperty
   a_idle: assert property (p_idle) else $error("output active while idle");
   property p_rot;
      ph_reg != 4'h0 && motor_phase != 4'h0 && motor_phase != ph_reg
         |-> motor_phase == {ph_reg[2:0], ph_reg[3]};
   endproperty
   a_rot: assert property (p_rot) else $error("motor phase skipped");
   property p_step;
      $rose(row_capture) |-> motor_phase != ph_reg && ph_reg != 4'h0;
   endproperty
   a_step: assert property (p_step) else $error("latch without motor step");
   property p_cap;
      $fell(row_capture) |-> cap_reg == CAP;
   endproperty
   a_cap: assert property (p_cap) else $error("latch pulse length wrong");
   property p_noheat;
      row_capture |-> heat_pulse_group == 3'h0;
   endproperty
   a_noheat: assert property (p_noheat) else $error("strobe during latch");
   property p_xclk;
      $rose(xfer_clk) |-> xfer_clk [*4] ##1 !xfer_clk;
   endproperty
   a_xclk: assert property (p_xclk) else $error("transfer clock high time wrong");
   property p_data;
      $rose(xfer_clk) |-> $stable(serial_print_bit);
   endproperty
   a_data: assert property (p_data) else $error("data moved at clock rise");
   property p_start;
      $rose(busy) |-> motor_phase == held_reg;
   endproperty
   a_start: assert property (p_start) else $error("start phase not the held one");
endmodule // seq_props
bind print_sequencer seq_props u_props (
   .clk(clk), .rst(rst), .busy(busy), .serial_print_bit(serial_print_bit),
   .xfer_clk(xfer_clk), .row_capture(row_capture),
   .heat_pulse_group(heat_pulse_group), .motor_phase(motor_phase)
);
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the print sequencer with a head model.
// Inputs change on the falling clock edge; outputs are judged there too.
`timescale 1ns/1ps
`default_nettype none
`include "print_defines.svh"
module tb;
   localparam int W = `LINE_DOTS;
   localparam int G = `GROUP_DOTS;
   logic clk, rst, limit_high, fixed_division, line_valid;
   logic [19:0] pulse_single, pulse_cont;
   logic [23:0] step_cycles;
   logic [W-1:0] line_data, latched, heated;
   logic line_ready, busy, serial_print_bit, xfer_clk, row_capture;
   logic [2:0] heat_pulse_group;
   logic [3:0] motor_phase, exp_phase;
   logic printed;
   int line_bits, fail_count, checks;
   print_sequencer DUT (.clk(clk), .rst(rst), .limit_high(limit_high),
      .fixed_division(fixed_division), .pulse_single(pulse_single),
      .pulse_cont(pulse_cont), .step_cycles(step_cycles), .line_valid(line_valid),
      .line_ready(line_ready), .line_data(line_data), .busy(busy),
      .serial_print_bit(serial_print_bit), .xfer_clk(xfer_clk),
      .row_capture(row_capture), .heat_pulse_group(heat_pulse_group),
      .motor_phase(motor_phase));
   thermal_head_model u_head (.serial_print_bit(serial_print_bit), .xfer_clk(xfer_clk),
      .row_capture(row_capture), .heat_pulse_group(heat_pulse_group),
      .latched(latched), .heated(heated), .line_bits(line_bits));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Every wait is bounded; a hang ends the run as a failure
   task automatic tick(inout int n);
      @(negedge clk);
      n++;
      if (n > 9000) begin
         fail_count++;
         test_done();
      end
   endtask
   function automatic logic [W-1:0] dots(input int a, input int b, input int c);
      logic [G-1:0] ones;
      ones = '1;
      return {ones >> (G - c), ones >> (G - b), ones >> (G - a)};
   endfunction
   // Offers one line, then follows its step, latch and strobe passes
   task automatic do_line(input logic [W-1:0] d, input logic [2:0] m0, m1, m2,
      input int np);
      logic [2:0] m [3];
      logic was_idle;
      int n, w;
      m = '{m0, m1, m2};
      n = 0;
      while (line_ready !== 1'b1) tick(n);
      was_idle = (busy === 1'b0);
      if (was_idle) printed = 1'b0;
      w = printed ? int'(pulse_cont) : int'(pulse_single);
      line_valid = 1'b1;
      line_data = d;
      @(negedge clk);
      line_valid = 1'b0;
      // The motor is switched on one cycle after the take, from idle
      if (was_idle) begin
         @(negedge clk);
         check(W'(motor_phase), W'(exp_phase));
      end
      n = 0;
      while (row_capture !== 1'b1) tick(n);
      exp_phase = {exp_phase[2:0], exp_phase[3]};
      check(W'(motor_phase), W'(exp_phase));
      check(W'(line_bits), W'(W));
      n = 0;
      while (row_capture !== 1'b0) tick(n);
      check(latched, d);
      for (int p = 0; p < np; p++) begin
         check(heated, d & {{G{m[p][2]}}, {G{m[p][1]}}, {G{m[p][0]}}});
         n = 0;
         while (heat_pulse_group === m[p] && n < 100) begin
            @(negedge clk);
            n++;
         end
         check(W'(n), W'(w));
      end
      check(W'(heat_pulse_group), '0);
      printed = (d != '0);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0) tick(n);
      check(W'({motor_phase, heat_pulse_group}), '0);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_var_low;
      do_line(dots(100, 0, 0), 3'h7, 3'h0, 3'h0, 1);
      do_line('0, 3'h7, 3'h0, 3'h0, 1);
      do_line(dots(144, 144, 0), 3'h1, 3'h6, 3'h0, 2);
      wait_idle();
   endtask
   task automatic t_var_three;
      do_line(dots(144, 144, 144), 3'h1, 3'h2, 3'h4, 3);
      do_line(dots(100, 100, 80), 3'h1, 3'h2, 3'h4, 3);
      wait_idle();
   endtask
   task automatic t_var_high;
      limit_high = 1'b1;
      do_line(dots(144, 144, 144), 3'h3, 3'h4, 3'h0, 2);
      do_line(dots(10, 0, 0), 3'h7, 3'h0, 3'h0, 1);
      wait_idle();
   endtask
   task automatic t_fixed;
      fixed_division = 1'b1;
      limit_high = 1'b0;
      do_line(dots(1, 0, 0), 3'h1, 3'h2, 3'h4, 3);
      wait_idle();
      limit_high = 1'b1;
      do_line('0, 3'h3, 3'h4, 3'h0, 2);
      wait_idle();
   endtask
   initial begin
      rst = 1'b1;
      limit_high = 1'b0;
      fixed_division = 1'b0;
      line_valid = 1'b0;
      line_data = '0;
      pulse_single = 20'h0_0014;
      pulse_cont = 20'h0_000c;
      step_cycles = 24'h00_00c8;
      exp_phase = `PHASE_INIT;
      printed = 1'b0;
      fail_count = 0;
      checks = 0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      wait_idle();
      t_var_low();
      t_var_three();
      t_var_high();
      t_fixed();
      test_done();
   end
endmodule // tb
`default_nettype wire

// ### sim/thermal_head_model.sv
// Behavioural print head: shift path, line latch, strobe-gated drivers.
// Driven only by the controller's head pins; exposes state to the bench.
`timescale 1ns/1ps
`default_nettype none
`include "print_defines.svh"
module thermal_head_model (
   // Head link
   input wire logic serial_print_bit,
   input wire logic xfer_clk,
   input wire logic row_capture,
   input wire logic [2:0] heat_pulse_group,
   // Observation
   output logic [`LINE_DOTS-1:0] latched,
   output logic [`LINE_DOTS-1:0] heated,
   output var int line_bits
);
   localparam int G = `GROUP_DOTS;
   logic [`LINE_DOTS-1:0] shift_reg;
   int shifted;
   int seen;
   initial begin
      shift_reg = '0;
      latched = '0;
      shifted = 0;
      seen = 0;
      line_bits = 0;
   end
   always @(posedge xfer_clk) begin
      shift_reg <= {shift_reg[`LINE_DOTS-2:0], serial_print_bit};
      shifted <= shifted + 1;
   end
   // Bit count per line is kept so short or long transfers show up; the
   // running total is only read here, so each counter has a single writer
   always @(posedge row_capture) begin
      latched <= shift_reg;
      line_bits <= shifted - seen;
      seen <= shifted;
   end
   assign heated = latched & {{G{heat_pulse_group[2]}}, {G{heat_pulse_group[1]}},
      {G{heat_pulse_group[0]}}};
endmodule // thermal_head_model
`default_nettype wire
